// ---- common/occ_pkg.sv ----
/*
  Constants, types and state codes for the operator console control block.
  Assumes one 10 MHz clock and a synchronous active-low reset. The processor
  sequencer and the input-output section sit outside this block.
*/
// Summary of operation
// - Stop halts program, input-output continues
// - Clear resets all but input-output registers
// - Master clear resets every register
// - Operator loads start address into P
// - P shown continuously as six octal digits
// - Start executes instruction at P address
// - Fifteen jump switches each light indicator
// - Jump switches honoured while program runs
// - Four stop switches light upper indicator half
// - Actual selected stop lights lower half
// - Stop switches armable while program runs
// - One of sixteen channels chosen for bootstrap
// - Load reads bootstrap via selected channel
// - Program fault on bad opcode or address
// - Locked-out memory reference is program fault
// - Peripheral fault on power or cable loss
// - Bootstrap fault on error during loading
// - Two switches choose console input and output
// - Program may also set console device choice
package occ_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int OCC_ADDR_W  = 18;
  localparam int OCC_JUMP_N  = 15;
  localparam int OCC_STOP_N  = 4;
  localparam int OCC_CHAN_W  = 4;
  localparam int OCC_REG_AW  = 4;
  localparam int OCC_DATA_W  = 32;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [OCC_REG_AW-1:0] OCC_REG_STATUS  = 4'h0;
  localparam logic [OCC_REG_AW-1:0] OCC_REG_PADDR   = 4'h1;
  localparam logic [OCC_REG_AW-1:0] OCC_REG_CONSEL  = 4'h2;
  localparam logic [OCC_REG_AW-1:0] OCC_REG_SWITCH  = 4'h3;

  // Status field positions
  localparam int OCC_ST_RUN     = 0;
  localparam int OCC_ST_PFAULT  = 1;
  localparam int OCC_ST_EFAULT  = 2;
  localparam int OCC_ST_BFAULT  = 3;
  localparam int OCC_ST_BOOT    = 4;
  localparam int OCC_ST_HIT_LSB = 8;
  // Console select fields
  localparam int OCC_CS_IN      = 0;
  localparam int OCC_CS_OUT     = 1;
  localparam int OCC_CS_PROG    = 2;
  // Switch readback fields
  localparam int OCC_SW_STOP_LSB = 16;
  localparam int OCC_SW_CHAN_LSB = 20;

  localparam logic [OCC_ADDR_W-1:0] OCC_P_RESET = 18'h00000;
  localparam logic [OCC_DATA_W-1:0] OCC_ZERO    = 32'h00000000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OCC_HALT = 2'b00,
    OCC_RUN  = 2'b01,
    OCC_BOOT = 2'b10
  } occ_state_e;

  // Operator panel switch group
  typedef struct packed {
    logic                  stop_pb;
    logic                  clear_pb;
    logic                  mclear_pb;
    logic                  start_pb;
    logic                  load_p_pb;
    logic                  boot_pb;
    logic [OCC_ADDR_W-1:0] addr_sw;
    logic [OCC_JUMP_N-1:0] jump_sw;
    logic [OCC_STOP_N-1:0] stop_sw;
    logic [OCC_CHAN_W-1:0] chan_sw;
    logic                  in_sw;
    logic                  out_sw;
  } occ_panel_s;

  // Fault sources from the processor and peripherals
  typedef struct packed {
    logic bad_opcode;
    logic bad_addr;
    logic locked_ref;
    logic sync_power_lost;
    logic cable_open;
    logic boot_error;
  } occ_fault_s;

endpackage : occ_pkg

// ---- src/occ_console.sv ----
/*
  Operator console control: run/halt sequencing, P register, selective
  jump and stop lamps, bootstrap channel start, fault lamps, console
  device selection and a small register port.
  Assumes panel switches are debounced and synchronous; push buttons are
  one-cycle pulses; the processor reports stop hits and boot completion.
*/
`timescale 1ns/1ps
module occ_console (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire occ_pkg::occ_panel_s           panel,
  input  wire occ_pkg::occ_fault_s           fault,
  input  wire logic [occ_pkg::OCC_STOP_N-1:0] stop_hit,
  input  wire logic                          instr_done,
  input  wire logic [occ_pkg::OCC_ADDR_W-1:0] next_p,
  input  wire logic                          boot_done,
  input  wire logic [occ_pkg::OCC_REG_AW-1:0] reg_addr,
  input  wire logic [occ_pkg::OCC_DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [occ_pkg::OCC_DATA_W-1:0]     reg_rdata,
  output logic                               run,
  output logic                               fetch_go,
  output logic                               cpu_clear,
  output logic                               io_clear,
  output logic [occ_pkg::OCC_ADDR_W-1:0]     p_disp,
  output logic [occ_pkg::OCC_JUMP_N-1:0]     jump_lamp,
  output logic [occ_pkg::OCC_STOP_N-1:0]     stop_upper_lamp,
  output logic [occ_pkg::OCC_STOP_N-1:0]     stop_lower_lamp,
  output logic                               boot_go,
  output logic [occ_pkg::OCC_CHAN_W-1:0]     boot_chan,
  output logic                               pfault_lamp,
  output logic                               efault_lamp,
  output logic                               bfault_lamp,
  output logic                               con_in_tape,
  output logic                               con_out_punch
);

  // ****************************************
  // Run state
  // ****************************************
  occ_pkg::occ_state_e               state_reg;
  logic [occ_pkg::OCC_ADDR_W-1:0]    p_reg;
  logic [occ_pkg::OCC_STOP_N-1:0]    armed_hit;
  logic                              any_clear;
  logic                              prog_sel_reg;
  logic                              prog_in_reg;
  logic                              prog_out_reg;

  assign any_clear = panel.clear_pb | panel.mclear_pb;
  // Only armed stops halt the machine
  assign armed_hit = stop_hit & panel.stop_sw;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg <= occ_pkg::OCC_HALT;
    end
    else if (any_clear)
    begin
      state_reg <= occ_pkg::OCC_HALT;
    end
    else
    begin
      unique case (state_reg)
        occ_pkg::OCC_HALT:
        begin
          if (panel.boot_pb)
          begin
            state_reg <= occ_pkg::OCC_BOOT;
          end
          else if (panel.start_pb)
          begin
            state_reg <= occ_pkg::OCC_RUN;
          end
        end
        occ_pkg::OCC_RUN:
        begin
          // Halt only stops the sequencer; io_clear stays low, so transfers finish
          if (panel.stop_pb || (|armed_hit))
          begin
            state_reg <= occ_pkg::OCC_HALT;
          end
        end
        occ_pkg::OCC_BOOT:
        begin
          if (boot_done || fault.boot_error)
          begin
            state_reg <= occ_pkg::OCC_HALT;
          end
        end
        default:
        begin
          state_reg <= occ_pkg::OCC_HALT;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      run      <= 1'b0;
      fetch_go <= 1'b0;
      boot_go  <= 1'b0;
    end
    else
    begin
      run      <= (state_reg == occ_pkg::OCC_RUN);
      // Pulse telling the sequencer to fetch from P
      fetch_go <= (state_reg == occ_pkg::OCC_HALT) && panel.start_pb
                  && !panel.boot_pb && !any_clear;
      boot_go  <= (state_reg == occ_pkg::OCC_HALT) && panel.boot_pb
                  && !any_clear;
    end
  end

  // ****************************************
  // Clears
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cpu_clear <= 1'b1;
      io_clear  <= 1'b1;
    end
    else
    begin
      cpu_clear <= any_clear;
      io_clear  <= panel.mclear_pb;
    end
  end

  // ****************************************
  // P register
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b || any_clear)
    begin
      p_reg <= occ_pkg::OCC_P_RESET;
    end
    else if (state_reg != occ_pkg::OCC_RUN && panel.load_p_pb)
    begin
      // Panel entry is ignored while running to avoid corrupting sequencing
      p_reg <= panel.addr_sw;
    end
    else if (state_reg != occ_pkg::OCC_RUN && reg_wr && reg_addr == occ_pkg::OCC_REG_PADDR)
    begin
      p_reg <= reg_wdata[occ_pkg::OCC_ADDR_W-1:0];
    end
    else if (state_reg == occ_pkg::OCC_RUN && instr_done)
    begin
      p_reg <= next_p;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      p_disp <= occ_pkg::OCC_P_RESET;
    end
    else
    begin
      p_disp <= p_reg;
    end
  end

  // ****************************************
  // Jump and stop lamps
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      jump_lamp       <= '0;
      stop_upper_lamp <= '0;
    end
    else
    begin
      jump_lamp       <= panel.jump_sw;
      stop_upper_lamp <= panel.stop_sw;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      stop_lower_lamp <= '0;
    end
    else if (state_reg == occ_pkg::OCC_RUN && !panel.stop_pb && (|armed_hit))
    begin
      // Stop reached in a clear cycle still shows; set beats clear
      stop_lower_lamp <= armed_hit;
    end
    else if (any_clear || (panel.start_pb && state_reg == occ_pkg::OCC_HALT))
    begin
      stop_lower_lamp <= '0;
    end
  end

  // ****************************************
  // Bootstrap channel
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      boot_chan <= '0;
    end
    else if (state_reg != occ_pkg::OCC_BOOT)
    begin
      // Frozen during loading so the source cannot change mid-load
      boot_chan <= panel.chan_sw;
    end
  end

  // ****************************************
  // Fault lamps; a new fault beats a clear
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pfault_lamp <= 1'b0;
      efault_lamp <= 1'b0;
      bfault_lamp <= 1'b0;
    end
    else
    begin
      pfault_lamp <= (fault.bad_opcode | fault.bad_addr | fault.locked_ref)
                     | (pfault_lamp & !any_clear);
      efault_lamp <= (fault.sync_power_lost | fault.cable_open)
                     | (efault_lamp & !any_clear);
      bfault_lamp <= (fault.boot_error & (state_reg == occ_pkg::OCC_BOOT))
                     | (bfault_lamp & !any_clear);
    end
  end

  // ****************************************
  // Console device selection
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b || panel.mclear_pb)
    begin
      prog_sel_reg <= 1'b0;
      prog_in_reg  <= 1'b0;
      prog_out_reg <= 1'b0;
    end
    else if (reg_wr && reg_addr == occ_pkg::OCC_REG_CONSEL)
    begin
      prog_sel_reg <= reg_wdata[occ_pkg::OCC_CS_PROG];
      prog_in_reg  <= reg_wdata[occ_pkg::OCC_CS_IN];
      prog_out_reg <= reg_wdata[occ_pkg::OCC_CS_OUT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      con_in_tape   <= 1'b0;
      con_out_punch <= 1'b0;
    end
    else
    begin
      con_in_tape   <= prog_sel_reg ? prog_in_reg : panel.in_sw;
      con_out_punch <= prog_sel_reg ? prog_out_reg : panel.out_sw;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      reg_rdata <= occ_pkg::OCC_ZERO;
    end
    else
    begin
      reg_rdata <= occ_pkg::OCC_ZERO;
      if (reg_rd)
      begin
        unique case (reg_addr)
          occ_pkg::OCC_REG_STATUS:
          begin
            reg_rdata[occ_pkg::OCC_ST_RUN]    <= (state_reg == occ_pkg::OCC_RUN);
            reg_rdata[occ_pkg::OCC_ST_PFAULT] <= pfault_lamp;
            reg_rdata[occ_pkg::OCC_ST_EFAULT] <= efault_lamp;
            reg_rdata[occ_pkg::OCC_ST_BFAULT] <= bfault_lamp;
            reg_rdata[occ_pkg::OCC_ST_BOOT]   <= (state_reg == occ_pkg::OCC_BOOT);
            reg_rdata[occ_pkg::OCC_ST_HIT_LSB +: occ_pkg::OCC_STOP_N] <= stop_lower_lamp;
          end
          occ_pkg::OCC_REG_PADDR:
          begin
            reg_rdata[occ_pkg::OCC_ADDR_W-1:0] <= p_reg;
          end
          occ_pkg::OCC_REG_CONSEL:
          begin
            reg_rdata[occ_pkg::OCC_CS_IN]   <= prog_in_reg;
            reg_rdata[occ_pkg::OCC_CS_OUT]  <= prog_out_reg;
            reg_rdata[occ_pkg::OCC_CS_PROG] <= prog_sel_reg;
          end
          occ_pkg::OCC_REG_SWITCH:
          begin
            // Program samples jump switches live while running
            reg_rdata[occ_pkg::OCC_JUMP_N-1:0] <= panel.jump_sw;
            reg_rdata[occ_pkg::OCC_SW_STOP_LSB +: occ_pkg::OCC_STOP_N] <= panel.stop_sw;
            reg_rdata[occ_pkg::OCC_SW_CHAN_LSB +: occ_pkg::OCC_CHAN_W] <= panel.chan_sw;
          end
          default:
          begin
            reg_rdata <= occ_pkg::OCC_ZERO;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  stop_halts_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == occ_pkg::OCC_RUN && panel.stop_pb && !any_clear)
    |=> (state_reg == occ_pkg::OCC_HALT) && !io_clear)
    else $error("stop did not halt or cleared io");
  clear_keeps_io_a: assert property (@(posedge clock) disable iff (!rst_b)
    (panel.clear_pb && !panel.mclear_pb) |=> cpu_clear && !io_clear && p_reg == '0)
    else $error("clear touched io or missed P");
  mclear_all_a: assert property (@(posedge clock) disable iff (!rst_b)
    panel.mclear_pb |=> cpu_clear && io_clear && !prog_sel_reg)
    else $error("master clear incomplete");
  p_load_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == occ_pkg::OCC_HALT && panel.load_p_pb && !any_clear)
    |=> p_reg == $past(panel.addr_sw) ##1 p_disp == $past(panel.addr_sw, 2))
    else $error("P load or display wrong");
  start_fetch_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == occ_pkg::OCC_HALT && panel.start_pb && !panel.boot_pb && !any_clear)
    |=> fetch_go && state_reg == occ_pkg::OCC_RUN ##1 run)
    else $error("start did not run");
  jump_lamp_a: assert property (@(posedge clock) disable iff (!rst_b)
    1'b1 |=> jump_lamp == $past(panel.jump_sw))
    else $error("jump lamp mismatch");
  stop_lower_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == occ_pkg::OCC_RUN && |armed_hit && !any_clear && !panel.stop_pb)
    |=> stop_lower_lamp == $past(armed_hit) && state_reg == occ_pkg::OCC_HALT)
    else $error("selected stop not shown");
  pfault_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (pfault_lamp && !any_clear) |=> pfault_lamp)
    else $error("program fault lamp dropped");
  locked_fault_a: assert property (@(posedge clock) disable iff (!rst_b)
    fault.locked_ref |=> pfault_lamp)
    else $error("locked reference not flagged");
  boot_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == occ_pkg::OCC_HALT && panel.boot_pb && !any_clear)
    |=> boot_go && boot_chan == $past(panel.chan_sw))
    else $error("boot start or channel wrong");
  pdisp_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
    1'b1 |=> p_disp == $past(p_reg))
    else $error("P display lags wrong");
  boot_chan_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == occ_pkg::OCC_BOOT) |=> boot_chan == $past(boot_chan))
    else $error("boot channel moved during load");
  efault_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    (fault.sync_power_lost || fault.cable_open) |=> efault_lamp)
    else $error("peripheral fault not shown");
  bfault_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == occ_pkg::OCC_BOOT && fault.boot_error)
    |=> bfault_lamp && state_reg == occ_pkg::OCC_HALT)
    else $error("bootstrap fault not shown");

endmodule : occ_console

// ---- dv/occ_cpu_model.sv ----
/*
  Processor sequencer stand-in: steps P and finishes bootstrap loads.
  Assumes the bench clock and synchronous active-low reset are shared.
*/
`timescale 1ns/1ps
module occ_cpu_model (
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  input  wire logic                           step_en,
  input  wire logic                           boot_go,
  input  wire logic [occ_pkg::OCC_ADDR_W-1:0] p_disp,
  output logic                                instr_done,
  output logic [occ_pkg::OCC_ADDR_W-1:0]      next_p,
  output logic                                boot_done
);
  logic [1:0] step_reg;
  logic [4:0] boot_reg;

  // ****************************************
  // Instruction stepping
  // ****************************************
  // Steps even when halted, so a halt that ignores it can be seen
  always_ff @(posedge clock)
  begin
    if (!rst_b || !step_en)
    begin
      step_reg   <= 2'h0;
      instr_done <= 1'b0;
    end
    else
    begin
      step_reg   <= step_reg + 2'h1;
      instr_done <= (step_reg == 2'h3);
    end
  end
  assign next_p = p_disp + 18'h00001;

  // ****************************************
  // Bootstrap completion
  // ****************************************
  // Slow on purpose: faults must be injected while loading
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      boot_reg  <= 5'h00;
      boot_done <= 1'b0;
    end
    else
    begin
      boot_done <= (boot_reg == 5'h01);
      if (boot_go)
        boot_reg <= 5'h14;
      else if (boot_reg != 5'h00)
        boot_reg <= boot_reg - 5'h01;
    end
  end
endmodule : occ_cpu_model

// ---- dv/occ_console_test.sv ----
/*
  Self-checking bench for the console block: panel, faults, registers.
  Assumes the processor stand-in model beside the design.
*/
`timescale 1ns/1ps
module occ_console_test;
  localparam int PW = $bits(occ_pkg::occ_panel_s);
  logic                            clock;
  logic                            rst_b;
  occ_pkg::occ_panel_s             panel;
  occ_pkg::occ_fault_s             fault;
  logic [occ_pkg::OCC_STOP_N-1:0]  stop_hit;
  logic                            instr_done;
  logic [occ_pkg::OCC_ADDR_W-1:0]  next_p;
  logic                            boot_done;
  logic                            step_en;
  logic [occ_pkg::OCC_REG_AW-1:0]  reg_addr;
  logic [occ_pkg::OCC_DATA_W-1:0]  reg_wdata;
  logic                            reg_wr;
  logic                            reg_rd;
  logic [occ_pkg::OCC_DATA_W-1:0]  reg_rdata;
  logic                            run;
  logic                            fetch_go;
  logic                            cpu_clear;
  logic                            io_clear;
  logic [occ_pkg::OCC_ADDR_W-1:0]  p_disp;
  logic [occ_pkg::OCC_JUMP_N-1:0]  jump_lamp;
  logic [occ_pkg::OCC_STOP_N-1:0]  stop_upper_lamp;
  logic [occ_pkg::OCC_STOP_N-1:0]  stop_lower_lamp;
  logic                            boot_go;
  logic [occ_pkg::OCC_CHAN_W-1:0]  boot_chan;
  logic                            pfault_lamp;
  logic                            efault_lamp;
  logic                            bfault_lamp;
  logic                            con_in_tape;
  logic                            con_out_punch;
  logic [31:0]                     rd;
  logic [occ_pkg::OCC_ADDR_W-1:0]  p0;
  int                              mismatches;
  int                              check_count;
  int                              cyc;

  occ_console dut_u (.clock(clock), .rst_b(rst_b), .panel(panel), .fault(fault),
    .stop_hit(stop_hit), .instr_done(instr_done), .next_p(next_p), .boot_done(boot_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .run(run), .fetch_go(fetch_go), .cpu_clear(cpu_clear),
    .io_clear(io_clear), .p_disp(p_disp), .jump_lamp(jump_lamp),
    .stop_upper_lamp(stop_upper_lamp), .stop_lower_lamp(stop_lower_lamp),
    .boot_go(boot_go), .boot_chan(boot_chan), .pfault_lamp(pfault_lamp),
    .efault_lamp(efault_lamp), .bfault_lamp(bfault_lamp), .con_in_tape(con_in_tape),
    .con_out_punch(con_out_punch));

  occ_cpu_model cpu_u (.clock(clock), .rst_b(rst_b), .step_en(step_en), .boot_go(boot_go),
    .p_disp(p_disp), .instr_done(instr_done), .next_p(next_p), .boot_done(boot_done));

  // ****************************************
  // Clock and timeout
  // ****************************************
  always #50 clock = ~clock;
  // Ceiling far above the roughly 180 cycles the tests take
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk

  // Bits: stop, clear, mclear, start, load_p, boot
  task automatic press(input logic [5:0] m);
    @(posedge clock) panel[PW-1 -: 6] <= m;
    @(posedge clock) panel[PW-1 -: 6] <= 6'h00;
    #1;
  endtask : press

  task automatic zap(input logic [5:0] m);
    @(posedge clock) fault <= m;
    @(posedge clock) fault <= 6'h00;
    #1;
  endtask : zap

  task automatic hit(input logic [3:0] m);
    @(posedge clock) stop_hit <= m;
    @(posedge clock) stop_hit <= 4'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask : hit

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock) reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_n

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    clock = 1'b0; rst_b = 1'b0; panel = '0; fault = '0; stop_hit = 4'h0; step_en = 1'b0;
    reg_addr = 4'h0; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    mismatches = 0; check_count = 0; cyc = 0;
    wait_n(5);
    chk("io_clear in reset", 32'h1, io_clear);
    rst_b <= 1'b1;
    reg_read(occ_pkg::OCC_REG_STATUS, rd);
    chk("status at reset", 32'h0, rd);
    reg_read(4'h7, rd);
    chk("unmapped read", 32'h0, rd);
    $display("test reset done");

    reg_write(occ_pkg::OCC_REG_PADDR, 32'h00001234);
    reg_read(occ_pkg::OCC_REG_PADDR, rd);
    chk("paddr write", 32'h00001234, rd);
    @(posedge clock) panel.addr_sw <= 18'h2A5B3;
    press(6'h02);
    wait_n(1);
    chk("p_disp load", 32'h2A5B3, p_disp);
    $display("test load done");

    press(6'h04);
    chk("fetch_go", 32'h1, fetch_go);
    wait_n(1);
    chk("run", 32'h1, run);
    chk("p at start", 32'h2A5B3, p_disp);
    reg_write(occ_pkg::OCC_REG_PADDR, 32'h0);
    @(posedge clock) panel.addr_sw <= 18'h00777;
    press(6'h02);
    reg_read(occ_pkg::OCC_REG_PADDR, rd);
    chk("p while running", 32'h2A5B3, rd);
    @(posedge clock);
    panel.jump_sw <= 15'h5A5A;
    panel.stop_sw <= 4'h9;
    panel.chan_sw <= 4'hC;
    wait_n(2);
    chk("jump lamps", 32'h5A5A, jump_lamp);
    chk("stop upper", 32'h9, stop_upper_lamp);
    reg_read(occ_pkg::OCC_REG_SWITCH, rd);
    chk("switch reg", 32'h00C95A5A, rd);
    hit(4'h2);
    chk("unarmed hit", 32'h1, run);
    hit(4'h8);
    chk("armed hit halt", 32'h0, run);
    chk("stop lower", 32'h8, stop_lower_lamp);
    reg_read(occ_pkg::OCC_REG_STATUS, rd);
    chk("status lower", 32'h00000800, rd);
    $display("test run done");

    step_en <= 1'b1;
    press(6'h04);
    wait_n(1);
    chk("lower cleared", 32'h0, stop_lower_lamp);
    p0 = p_disp;
    wait_n(16);
    chk("p advances", 32'h1, p_disp != p0);
    press(6'h20);
    wait_n(1);
    chk("stop halts", 32'h0, run);
    chk("stop keeps io", 32'h0, io_clear);
    p0 = p_disp;
    wait_n(12);
    chk("p frozen", p0, p_disp);
    step_en <= 1'b0;
    $display("test stop done");

    @(posedge clock) panel.in_sw <= 1'b1;
    wait_n(2);
    chk("manual in", 32'h1, con_in_tape);
    chk("manual out", 32'h0, con_out_punch);
    reg_write(occ_pkg::OCC_REG_CONSEL, 32'h6);
    wait_n(1);
    chk("prog in", 32'h0, con_in_tape);
    chk("prog out", 32'h1, con_out_punch);
    for (int i = 0; i < 6; i++)
    begin
      zap(6'h01 << i);
      chk("pfault", {31'h0, i >= 3}, pfault_lamp);
      chk("efault", {31'h0, i == 1 || i == 2}, efault_lamp);
      chk("bfault idle", 32'h0, bfault_lamp);
      wait_n(4);
      chk("lamps held", {31'h0, i > 0}, pfault_lamp | efault_lamp);
      press(6'h10);
      chk("cpu_clear", 32'h1, cpu_clear);
      chk("no io_clear", 32'h0, io_clear);
      wait_n(1);
      chk("lamps cleared", 32'h0, pfault_lamp | efault_lamp);
    end
    chk("p cleared", 32'h0, p_disp);
    reg_read(occ_pkg::OCC_REG_CONSEL, rd);
    chk("consel kept", 32'h6, rd);
    press(6'h08);
    chk("mclear io", 32'h1, io_clear);
    chk("mclear cpu", 32'h1, cpu_clear);
    reg_read(occ_pkg::OCC_REG_CONSEL, rd);
    chk("consel mcleared", 32'h0, rd);
    chk("manual again", 32'h1, con_in_tape);
    $display("test faults done");

    press(6'h01);
    chk("boot_go", 32'h1, boot_go);
    chk("boot_chan", 32'hC, boot_chan);
    @(posedge clock) panel.chan_sw <= 4'h3;
    reg_read(occ_pkg::OCC_REG_STATUS, rd);
    chk("status boot", 32'h00000010, rd);
    chk("chan frozen", 32'hC, boot_chan);
    zap(6'h01);
    chk("bfault", 32'h1, bfault_lamp);
    wait_n(30);
    chk("bfault held", 32'h1, bfault_lamp);
    press(6'h10);
    wait_n(1);
    chk("bfault cleared", 32'h0, bfault_lamp);
    chk("chan follows", 32'h3, boot_chan);
    $display("test boot done");
    end_sim();
  end
endmodule : occ_console_test
